/* dv/icp_master.sv */
// Behavioural two-wire bus master that drives the control port slave
`timescale 1ns/1ps
`default_nettype none
module icp_master #(
  parameter int Q = 625
) (
  // Resolved data line
  input  wire logic sda,
  // Driven lines
  output logic      scl,
  output logic      sda_oe
);
  logic [7:0] rx_byte;
  event       rx_ev;

  initial begin
    scl    = 1'b1;
    sda_oe = 1'b0;
  end

  // ==========================================================
  // Bus conditions
  task automatic start;
    sda_oe = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask : start

  // Legal from clock low, also in mid-byte
  task automatic rstart;
    #Q sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b0;
  endtask : rstart

  task automatic stop;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #(2*Q);
  endtask : stop

  // ==========================================================
  // Bits and bytes
  task automatic bit_x(input logic b, output logic r);
    #Q sda_oe = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask : bit_x

  // Ninth bit high releases the line: nack on reads, room for ack on writes
  task automatic byte_x(input logic [7:0] tx, input logic ninth, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx_byte[i]);
    end
    bit_x(ninth, ack);
    ->rx_ev;
  endtask : byte_x
endmodule : icp_master
`default_nettype wire

/* dv/icp_slave_bench.sv */
// Self-checking testbench of the two-wire control port slave
`timescale 1ns/1ps
`default_nettype none
module icp_slave_bench;
  import icp_pkg::*;
  logic          clk;
  logic          reset;
  logic          link_clk;
  logic          link_reset;
  logic          scl;
  logic          m_oe;
  wire           sda;
  wire           sda_out;
  wire           sda_oe;
  wire           spi_enable;
  icp_tri_t      sel_hi;
  icp_tri_t      sel_lo;
  wire icp_req_s reg_req;
  wire           reg_valid;
  logic [7:0]    reg_rdata = 8'h00;
  int            mismatches;
  int            checks;
  logic [31:0]   rng;
  logic [15:0]   ptr;
  logic [6:0]    own;
  logic          b;
  logic [7:0]    bq[$];
  logic [23:0]   wq[$];

  // Open drain: any pull wins, else pulled up
  assign sda = ~(m_oe | sda_oe);

  icp_slave dut_u (
    .clk                  (clk),
    .reset                (reset),
    .link_clk             (link_clk),
    .link_reset           (link_reset),
    .scl_in               (scl),
    .sda_in               (sda),
    .sda_out              (sda_out),
    .sda_oe               (sda_oe),
    .port_select_high_pin (sel_hi),
    .port_select_low_pin  (sel_lo),
    .spi_enable           (spi_enable),
    .reg_req              (reg_req),
    .reg_valid            (reg_valid),
    .reg_rdata            (reg_rdata)
  );

  icp_master m_u (
    .sda    (sda),
    .scl    (scl),
    .sda_oe (m_oe)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Offset so the two clocks never share edges
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rd_of(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : rd_of

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic wb(input logic [7:0] tx, input logic ea);
    logic a;
    bq.push_back(tx);
    m_u.byte_x(tx, 1'b1, a);
    chk("ack", 24'(a), 24'(ea));
  endtask : wb

  task automatic wd(input logic [7:0] d);
    wq.push_back({ptr, d});
    wb(d, 1'b0);
    ptr++;
  endtask : wd

  task automatic setp(input logic [15:0] p);
    m_u.start();
    wb({own, 1'b0}, 1'b0);
    wb(p[15:8], 1'b0);
    wb(p[7:0], 1'b0);
    ptr = p;
  endtask : setp

  task automatic rd(input logic last);
    logic a;
    bq.push_back(rd_of(ptr));
    m_u.byte_x(8'hFF, last, a);
    ptr++;
  endtask : rd

  // ==========================================================
  // Result monitors
  always @(posedge clk) begin
    if (reg_valid === 1'b1) begin
      reg_rdata <= rd_of(reg_req.addr);
      if (reg_req.write === 1'b1) begin
        if (wq.size() == 0) begin
          chk("stray write", 24'h1, 24'h0);
        end else begin
          chk("write", {reg_req.addr, reg_req.data}, wq.pop_front());
        end
      end
    end
  end

  always begin
    @(m_u.rx_ev);
    if (bq.size() == 0) begin
      chk("stray byte", 24'h1, 24'h0);
    end else begin
      chk("byte", 24'(m_u.rx_byte), 24'(bq.pop_front()));
    end
  end

  always @(posedge link_clk) begin
    if (sda_oe === 1'b1) begin
      chk("drive level", 24'(sda_out), 24'h0);
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    reset      = 1'b1;
    link_reset = 1'b1;
    sel_hi     = 2'h1;
    sel_lo     = 2'h2;
    mismatches = 0;
    checks     = 0;
    rng        = 32'hBCD06381;
    repeat (10) @(posedge link_clk);
    link_reset <= 1'b0;
    @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge link_clk);
    // Every strap pair: own address answered unless both straps high select SPI, neighbour ignored
    for (int h = 0; h < 3; h++) begin
      for (int l = 0; l < 3; l++) begin
        @(posedge clk);
        sel_hi <= icp_tri_t'(h);
        sel_lo <= icp_tri_t'(l);
        own = {4'hB, 3'(h * 3 + l)};
        repeat (10) @(posedge link_clk);
        chk("spi enable", 24'(spi_enable), 24'(h == 2 && l == 2));
        m_u.start();
        wb({own, 1'b0}, 1'(h == 2 && l == 2));
        m_u.stop();
        m_u.start();
        wb({own + 7'h1, 1'b0}, 1'b1);
        m_u.stop();
      end
    end
    @(posedge clk);
    sel_hi <= 2'h1;
    sel_lo <= 2'h2;
    own = 7'h5D;
    repeat (10) @(posedge link_clk);
    // Burst write at a random pointer
    rng = xs(rng);
    setp(rng[15:0]);
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      wd(rng[7:0]);
    end
    m_u.stop();
    // Pointer-only write, then plain read ending in nack
    rng = xs(rng);
    setp(rng[15:0]);
    m_u.stop();
    m_u.start();
    wb({own, 1'b1}, 1'b0);
    rd(1'b0);
    rd(1'b0);
    rd(1'b1);
    repeat (8) @(posedge link_clk);
    chk("release", 24'(sda_oe), 24'h0);
    m_u.stop();
    // Repeated start inside a byte, then combined read
    rng = xs(rng);
    setp(rng[15:0]);
    for (int k = 0; k < 4; k++) begin
      m_u.bit_x(rng[k], b);
    end
    m_u.rstart();
    wb({own, 1'b1}, 1'b0);
    rd(1'b0);
    rd(1'b1);
    m_u.stop();
    // Stop inside a data byte drops it
    rng = xs(rng);
    setp(rng[15:0]);
    wd(rng[23:16]);
    for (int k = 0; k < 3; k++) begin
      m_u.bit_x(rng[k], b);
    end
    m_u.stop();
    m_u.start();
    wb({own, 1'b1}, 1'b0);
    rd(1'b1);
    m_u.stop();
    repeat (20) @(posedge clk);
    chk("pending", 24'(wq.size() + bq.size()), 24'h0);
    final_report();
  end
endmodule : icp_slave_bench
`default_nettype wire

/* rtl/icp_pkg.sv */
// Types of the two-wire control port slave
`default_nettype none
package icp_pkg;
  typedef enum logic [2:0] {
    ICP_IDLE,
    ICP_ADDR,
    ICP_WACK,
    ICP_WRX,
    ICP_TX
  } icp_state_e;

  typedef logic [1:0] icp_tri_t;

  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  data;
  } icp_req_s;
endpackage : icp_pkg
`default_nettype wire

/* rtl/icp_regs.svh */
// Constants of the two-wire control port slave
`ifndef ICP_REGS_SVH
`define ICP_REGS_SVH
// Slave address fixed upper bits
`define ICP_ADDR_UPPER   4'hB
// Three-level strap codes and weighting of the high pin
`define ICP_TRI_LOW      2'h0
`define ICP_TRI_OPEN     2'h1
`define ICP_TRI_HIGH     2'h2
`define ICP_HI_WEIGHT    3'h3
// Bit positions inside a received byte
`define ICP_MSB          7
`define ICP_DIR_BIT      0
`define ICP_ADDR_LSB     1
// Rising-edge count within a byte: data bits 0..7, acknowledge at 8
`define ICP_BIT_FIRST    4'h0
`define ICP_BIT_LAST     4'h7
`define ICP_BIT_ACK      4'h8
// Byte position after a write address byte
`define ICP_BYTE_ADDR_HI 2'h0
`define ICP_BYTE_ADDR_LO 2'h1
`define ICP_BYTE_DATA    2'h2
// Idle level of both bus lines and pointer step
`define ICP_LINE_IDLE    1'b1
`define ICP_PTR_STEP     16'h0001
`endif

/* rtl/icp_slave.sv */
// Two-wire control port slave: bus protocol, strap decode, register access crossing
`timescale 1ns/1ps
`default_nettype none
`include "icp_regs.svh"

// ==========================================================
// Three-stage input sampler with agreement filter
module icp_sync3 #(
  parameter int unsigned      WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // Sampling clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Foreign input and accepted value
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Only the later two stages decide; the first may be metastable
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= INIT;
    end else if (s2_reg == s3_reg) begin
      q <= s3_reg;
    end
  end
endmodule : icp_sync3

// ==========================================================
// Control port slave top
module icp_slave (
  // Core clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Link sampling clock and reset
  input  wire logic               link_clk,
  input  wire logic               link_reset,
  // Bus pins
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output wire logic               sda_out,
  output wire logic               sda_oe,
  // Port select straps
  input  wire icp_pkg::icp_tri_t  port_select_high_pin,
  input  wire icp_pkg::icp_tri_t  port_select_low_pin,
  output wire logic               spi_enable,
  // Register file access, core domain
  output wire icp_pkg::icp_req_s  reg_req,
  output wire logic               reg_valid,
  input  wire logic [7:0]         reg_rdata
);
  import icp_pkg::*;

  // ========================================================
  // Link side sampling
  logic       scl_f;
  logic       sda_f;
  icp_tri_t   sel_hi_f;
  icp_tri_t   sel_lo_f;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  // Oversampling on the link clock leaves many samples per fast-mode bit
  icp_sync3 #(.WIDTH(1), .INIT(`ICP_LINE_IDLE)) u_scl_sync (
    .clk   (link_clk),
    .reset (link_reset),
    .d     (scl_in),
    .q     (scl_f)
  );
  icp_sync3 #(.WIDTH(1), .INIT(`ICP_LINE_IDLE)) u_sda_sync (
    .clk   (link_clk),
    .reset (link_reset),
    .d     (sda_in),
    .q     (sda_f)
  );
  icp_sync3 #(.WIDTH(2), .INIT(`ICP_TRI_LOW)) u_hi_sync (
    .clk   (link_clk),
    .reset (link_reset),
    .d     (port_select_high_pin),
    .q     (sel_hi_f)
  );
  icp_sync3 #(.WIDTH(2), .INIT(`ICP_TRI_LOW)) u_lo_sync (
    .clk   (link_clk),
    .reset (link_reset),
    .d     (port_select_low_pin),
    .q     (sel_lo_f)
  );

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      scl_d_reg <= `ICP_LINE_IDLE;
      sda_d_reg <= `ICP_LINE_IDLE;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  assign scl_rise  = scl_f && !scl_d_reg;
  assign scl_fall  = !scl_f && scl_d_reg;
  assign start_det = scl_f && scl_d_reg && sda_d_reg && !sda_f;
  assign stop_det  = scl_f && scl_d_reg && !sda_d_reg && sda_f;

  // ========================================================
  // Port select and own address
  logic       spi_enable_reg;
  logic [2:0] own_low_reg;

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      spi_enable_reg <= 1'b0;
      own_low_reg    <= 3'h0;
    end else begin
      spi_enable_reg <= (sel_hi_f == `ICP_TRI_HIGH) && (sel_lo_f == `ICP_TRI_HIGH);
      own_low_reg    <= 3'({1'b0, sel_hi_f} * `ICP_HI_WEIGHT + {1'b0, sel_lo_f});
    end
  end

  // ========================================================
  // Protocol engine
  icp_state_e  state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_next_reg;
  logic        sda_oe_reg;
  logic        sda_out_reg;
  logic        dir_read_reg;
  logic [1:0]  byte_idx_reg;
  logic [15:0] ptr_reg;
  logic        addr_match;
  logic        byte_done;
  logic        addr_hit;
  logic        wr_byte;
  logic        wr_req;
  logic        rd_first;
  logic        rd_next;
  logic        tx_sent;

  assign addr_match = shift_reg[`ICP_MSB:`ICP_ADDR_LSB] == {`ICP_ADDR_UPPER, own_low_reg};
  assign byte_done  = scl_fall && (bit_cnt_reg == `ICP_BIT_ACK);
  assign addr_hit   = byte_done && (state_reg == ICP_ADDR) && addr_match;
  assign wr_byte    = byte_done && (state_reg == ICP_WRX);
  assign wr_req     = wr_byte && (byte_idx_reg == `ICP_BYTE_DATA);
  assign rd_first   = addr_hit && shift_reg[`ICP_DIR_BIT];
  assign rd_next    = scl_fall && (state_reg == ICP_TX) && (bit_cnt_reg == `ICP_BIT_LAST);
  assign tx_sent    = scl_rise && (state_reg == ICP_TX) && (bit_cnt_reg == `ICP_BIT_ACK);

  // No power-down input exists here, so the port answers in chip sleep
  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      state_reg   <= ICP_IDLE;
      bit_cnt_reg <= `ICP_BIT_FIRST;
      shift_reg   <= 8'h00;
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      // Open drain: the driven level is always low; no clock pin exists
      sda_out_reg <= 1'b0;
      if (stop_det) begin
        state_reg  <= ICP_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (start_det) begin
        state_reg   <= spi_enable_reg ? ICP_IDLE : ICP_ADDR;
        bit_cnt_reg <= `ICP_BIT_FIRST;
        sda_oe_reg  <= 1'b0;
      end else if (state_reg != ICP_IDLE) begin
        if (scl_rise) begin
          bit_cnt_reg <= (bit_cnt_reg == `ICP_BIT_ACK) ? `ICP_BIT_FIRST : bit_cnt_reg + 4'h1;
          if ((state_reg == ICP_ADDR || state_reg == ICP_WRX) && bit_cnt_reg != `ICP_BIT_ACK) begin
            shift_reg <= {shift_reg[`ICP_MSB-1:0], sda_f};
          end
          if (tx_sent && sda_f) begin
            state_reg <= ICP_IDLE;
          end
        end else if (scl_fall) begin
          // Every drive change apart from the release at start and stop happens right after a falling clock
          unique case (state_reg)
            ICP_IDLE: begin
            end
            ICP_ADDR: begin
              if (bit_cnt_reg == `ICP_BIT_ACK) begin
                state_reg  <= addr_match ? ICP_WACK : ICP_IDLE;
                sda_oe_reg <= addr_match;
              end
            end
            ICP_WRX: begin
              if (bit_cnt_reg == `ICP_BIT_ACK) begin
                state_reg  <= ICP_WACK;
                sda_oe_reg <= 1'b1;
              end
            end
            ICP_WACK: begin
              if (bit_cnt_reg == `ICP_BIT_FIRST) begin
                if (dir_read_reg) begin
                  state_reg  <= ICP_TX;
                  shift_reg  <= tx_next_reg;
                  sda_oe_reg <= !tx_next_reg[`ICP_MSB];
                end else begin
                  state_reg  <= ICP_WRX;
                  sda_oe_reg <= 1'b0;
                end
              end
            end
            ICP_TX: begin
              if (bit_cnt_reg == `ICP_BIT_ACK) begin
                sda_oe_reg <= 1'b0;
              end else if (bit_cnt_reg == `ICP_BIT_FIRST) begin
                shift_reg  <= tx_next_reg;
                sda_oe_reg <= !tx_next_reg[`ICP_MSB];
              end else begin
                shift_reg  <= {shift_reg[`ICP_MSB-1:0], 1'b0};
                sda_oe_reg <= !shift_reg[`ICP_MSB-1];
              end
            end
          endcase
        end
      end
    end
  end

  // ========================================================
  // Transfer bookkeeping and address pointer
  // The pointer survives stop and repeated start, so a later read resumes here
  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      dir_read_reg <= 1'b0;
      byte_idx_reg <= `ICP_BYTE_ADDR_HI;
      ptr_reg      <= 16'h0000;
    end else if (addr_hit) begin
      dir_read_reg <= shift_reg[`ICP_DIR_BIT];
      byte_idx_reg <= `ICP_BYTE_ADDR_HI;
    end else if (wr_byte) begin
      unique case (byte_idx_reg)
        `ICP_BYTE_ADDR_HI: begin
          ptr_reg      <= {shift_reg, ptr_reg[`ICP_MSB:0]};
          byte_idx_reg <= `ICP_BYTE_ADDR_LO;
        end
        `ICP_BYTE_ADDR_LO: begin
          ptr_reg      <= {ptr_reg[15:8], shift_reg};
          byte_idx_reg <= `ICP_BYTE_DATA;
        end
        `ICP_BYTE_DATA: begin
          ptr_reg <= ptr_reg + `ICP_PTR_STEP;
        end
        default: begin
          byte_idx_reg <= `ICP_BYTE_DATA;
        end
      endcase
    end else if (tx_sent) begin
      ptr_reg <= ptr_reg + `ICP_PTR_STEP;
    end
  end

  // ========================================================
  // Requests toward the core domain
  icp_req_s req_reg;
  logic     req_tgl_reg;
  logic     ack_tgl_reg;
  logic     ack_f;
  logic     ack_d_reg;
  logic     ack_evt;
  logic [7:0] rdata_hold_reg;

  // Next read byte is fetched during the last bit, giving the crossing two bit times
  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      req_reg     <= '0;
      req_tgl_reg <= 1'b0;
    end else if (rd_first || rd_next || wr_req) begin
      req_reg.write <= wr_req;
      req_reg.addr  <= rd_next ? ptr_reg + `ICP_PTR_STEP : ptr_reg;
      req_reg.data  <= shift_reg;
      req_tgl_reg   <= !req_tgl_reg;
    end
  end

  icp_sync3 #(.WIDTH(1), .INIT(1'b0)) u_ack_sync (
    .clk   (link_clk),
    .reset (link_reset),
    .d     (ack_tgl_reg),
    .q     (ack_f)
  );
  assign ack_evt = ack_f != ack_d_reg;

  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      ack_d_reg   <= 1'b0;
      tx_next_reg <= 8'h00;
    end else begin
      ack_d_reg <= ack_f;
      if (ack_evt) begin
        tx_next_reg <= rdata_hold_reg;
      end
    end
  end

  // ========================================================
  // Core domain handshake
  logic     req_f;
  logic     req_d_reg;
  logic     req_evt;
  logic     reg_valid_reg;
  logic     cap_reg;
  icp_req_s req_out_reg;

  icp_sync3 #(.WIDTH(1), .INIT(1'b0)) u_req_sync (
    .clk   (clk),
    .reset (reset),
    .d     (req_tgl_reg),
    .q     (req_f)
  );
  assign req_evt = req_f != req_d_reg;

  // Request fields are held in the link domain until the acknowledge returns
  always_ff @(posedge clk) begin
    if (reset) begin
      req_d_reg      <= 1'b0;
      reg_valid_reg  <= 1'b0;
      cap_reg        <= 1'b0;
      req_out_reg    <= '0;
      rdata_hold_reg <= 8'h00;
      ack_tgl_reg    <= 1'b0;
    end else begin
      req_d_reg     <= req_f;
      reg_valid_reg <= req_evt;
      cap_reg       <= reg_valid_reg;
      if (req_evt) begin
        req_out_reg <= req_reg;
      end
      if (cap_reg) begin
        rdata_hold_reg <= reg_rdata;
        ack_tgl_reg    <= !ack_tgl_reg;
      end
    end
  end

  assign sda_out    = sda_out_reg;
  assign sda_oe     = sda_oe_reg;
  assign spi_enable = spi_enable_reg;
  assign reg_req    = req_out_reg;
  assign reg_valid  = reg_valid_reg;

  // ========================================================
  // Checks
  a_spi_select: assert property (
    @(posedge link_clk) disable iff (link_reset)
    $changed(sel_hi_f) || $changed(sel_lo_f) |=>
      spi_enable_reg == ($past(sel_hi_f) == `ICP_TRI_HIGH && $past(sel_lo_f) == `ICP_TRI_HIGH))
    else $error("port select decode wrong");
  a_start_addr: assert property (
    @(posedge link_clk) disable iff (link_reset)
    start_det && !spi_enable_reg |=> state_reg == ICP_ADDR && bit_cnt_reg == `ICP_BIT_FIRST && !sda_oe_reg)
    else $error("start not taken");
  a_stop_idle: assert property (
    @(posedge link_clk) disable iff (link_reset)
    stop_det |=> state_reg == ICP_IDLE && !sda_oe_reg)
    else $error("stop not taken");
  a_addr_ack: assert property (
    @(posedge link_clk) disable iff (link_reset)
    addr_hit |=> sda_oe_reg && state_reg == ICP_WACK)
    else $error("own address not acknowledged");
  a_idle_quiet: assert property (
    @(posedge link_clk) disable iff (link_reset)
    state_reg == ICP_IDLE |-> !sda_oe_reg)
    else $error("data line driven while idle");
  a_drive_low_scl: assert property (
    @(posedge link_clk) disable iff (link_reset)
    $changed(sda_oe_reg) |-> !scl_f || $past(start_det || stop_det))
    else $error("data line changed with clock high");
  a_bit_count: assert property (
    @(posedge link_clk) disable iff (link_reset)
    scl_rise && state_reg != ICP_IDLE && !start_det && !stop_det |=>
      bit_cnt_reg == ($past(bit_cnt_reg) == `ICP_BIT_ACK ? `ICP_BIT_FIRST : $past(bit_cnt_reg) + 4'h1))
    else $error("bit counter out of step");
  a_write_req: assert property (
    @(posedge link_clk) disable iff (link_reset)
    wr_req |=> req_tgl_reg != $past(req_tgl_reg) && req_reg.write && ptr_reg == $past(ptr_reg) + `ICP_PTR_STEP)
    else $error("write byte not posted");
  a_nack_release: assert property (
    @(posedge link_clk) disable iff (link_reset)
    tx_sent && sda_f && !start_det && !stop_det |=> state_reg == ICP_IDLE && !sda_oe_reg)
    else $error("no-acknowledge not honoured");
  a_core_pulse: assert property (
    @(posedge clk) disable iff (reset)
    req_evt |=> reg_valid_reg ##1 !reg_valid_reg ##1 ack_tgl_reg != $past(ack_tgl_reg))
    else $error("core handshake out of step");
endmodule : icp_slave
`default_nettype wire
